/* pkg/prl_pkg.sv */
// package with register map, fields and constants of the input remap block
// Function
// - lock bit 11 set: writes to the select registers are dropped, contents kept; keyed config writes still land
// - lock bit clear: remap registers accept writes; lock resets to zero
// - config register write only takes effect after the unlock sequence
// - config register bits other than lock read as zero
// - select 0 bits 15:8 pick the ext_irq1 pin; bits 7:0 unimplemented
// - select 1 bits 15:8 pick the ext_irq3 pin
// - select 1 bits 7:0 pick the ext_irq2 pin
// - select 2 bits 15:8 pick the timer1 clock pin; low byte unimplemented
// - unimplemented select bits ignore writes and read zero
// - every selector field is read/write and resets to zero
// - several selectors may name the same pin at once
package prl_pkg;
  localparam int          PIN_COUNT      = 64;
  localparam logic [7:0]  PIN_LAST       = 8'h3F;
  localparam logic [11:0] ADDR_CONFIG    = 12'h000;
  localparam logic [11:0] ADDR_SEL0      = 12'h004;
  localparam logic [11:0] ADDR_SEL1      = 12'h008;
  localparam logic [11:0] ADDR_SEL2      = 12'h00C;
  localparam logic [11:0] ADDR_KEY       = 12'h010;
  localparam int          LOCK_BIT       = 11;
  localparam logic [15:0] CONFIG_MASK    = 16'h0800;
  localparam logic [15:0] SEL_HI_MASK    = 16'hFF00;
  localparam logic [15:0] SEL_FULL_MASK  = 16'hFFFF;
  localparam logic [15:0] REG_RESET      = 16'h0000;
  localparam logic [31:0] KEY_FIRST      = 32'h0000_0055;
  localparam logic [31:0] KEY_SECOND     = 32'h0000_00AA;
  localparam logic [1:0]  HTRANS_NONSEQ  = 2'b10;
  localparam logic [2:0]  HSIZE_WORD     = 3'b010;
  typedef enum logic [1:0] {
    KEY_IDLE  = 2'b00,
    KEY_HALF  = 2'b01,
    KEY_OPEN  = 2'b10
  } prl_key_type;
endpackage

/* hdl/prl_remap.sv */
// input remap block: ahb-lite registers, lock, unlock keys, pin selectors
`timescale 1ns/1ps
module prl_remap
  import prl_pkg::*;
(
  input  wire logic        CLK,                   // system clock 100 MHz
  input  wire logic        RST_N,                 // async reset, active low
  input  wire logic        HSEL,                  // slave select
  input  wire logic [31:0] HADDR,                 // byte address
  input  wire logic [1:0]  HTRANS,                // transfer type
  input  wire logic        HWRITE,                // write when high
  input  wire logic [2:0]  HSIZE,                 // transfer size
  input  wire logic        HREADY,                // bus ready in
  input  wire logic [31:0] HWDATA,                // write data
  output logic      [31:0] HRDATA,                // read data
  output logic             HREADYOUT,             // slave ready
  output logic             HRESP,                 // always okay
  input  wire logic [63:0] PIN_IN,                // remappable pins
  output logic             EXT_IRQ1,              // routed ext_irq1
  output logic             EXT_IRQ2,              // routed ext_irq2
  output logic             EXT_IRQ3,              // routed ext_irq3
  output logic             TIMER1_EXT_CLOCK,      // routed timer1 clock
  output logic             REMAP_LOCK             // lock state
);

  // reset release synchroniser
  logic rst_meta_ff;
  logic rst_sync_ff;
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end
  wire logic rst_n = rst_sync_ff;

  // pin synchronisers; first stage read only by second
  logic [63:0] pin_meta_ff;
  logic [63:0] pin_sync_ff;
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta_ff <= '0;
      pin_sync_ff <= '0;
    end else begin
      pin_meta_ff <= PIN_IN;
      pin_sync_ff <= pin_meta_ff;
    end
  end

  // route one pin by index; out-of-range index gives zero
  function automatic logic pick_pin(input logic [63:0] pins,
                                    input logic [7:0]  sel);
    logic res;
    res = 1'b0;
    if (sel <= PIN_LAST) begin
      res = pins[sel[5:0]];
    end
    return res;
  endfunction

  // address phase capture
  logic        wr_pend_ff;
  logic        rd_pend_ff;
  logic [11:0] addr_ff;
  wire logic   take = HSEL && HREADY && (HTRANS == HTRANS_NONSEQ);
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend_ff <= 1'b0;
      rd_pend_ff <= 1'b0;
      addr_ff    <= 12'h000;
    end else begin
      wr_pend_ff <= take && HWRITE;
      rd_pend_ff <= take && !HWRITE;
      addr_ff    <= HADDR[11:0];
    end
  end

  // registers
  logic        lock_ff;
  logic [15:0] sel0_ff;
  logic [15:0] sel1_ff;
  logic [15:0] sel2_ff;
  prl_key_type key_ff;
  prl_key_type nxt_key;

  wire logic wr_cfg  = wr_pend_ff && (addr_ff == ADDR_CONFIG);
  wire logic wr_key  = wr_pend_ff && (addr_ff == ADDR_KEY);
  wire logic wr_ok   = wr_pend_ff && !lock_ff;
  wire logic wr_sel0 = wr_ok && (addr_ff == ADDR_SEL0);
  wire logic wr_sel1 = wr_ok && (addr_ff == ADDR_SEL1);
  wire logic wr_sel2 = wr_ok && (addr_ff == ADDR_SEL2);
  // config write only lands right after a full key pair
  wire logic cfg_take = wr_cfg && (key_ff == KEY_OPEN);

  // key sequencer; any other write or an idle cycle closes the window
  always_comb begin
    nxt_key = KEY_IDLE;
    case (key_ff)
      KEY_IDLE: begin
        if (wr_key && HWDATA == KEY_FIRST) nxt_key = KEY_HALF;
      end
      KEY_HALF: begin
        if (wr_key && HWDATA == KEY_SECOND) begin
          nxt_key = KEY_OPEN;
        end else if (wr_key && HWDATA == KEY_FIRST) begin
          nxt_key = KEY_HALF;
        end
      end
      KEY_OPEN: nxt_key = KEY_IDLE;
      default:  nxt_key = KEY_IDLE;
    endcase
  end

  // key state moves only on write data phases or out of open; opens for one data phase only
  logic half_seen_ff;
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      key_ff       <= KEY_IDLE;
      half_seen_ff <= 1'b0;
    end else if (wr_pend_ff || key_ff == KEY_OPEN) begin
      key_ff       <= nxt_key;
      half_seen_ff <= 1'b0;
    end else begin
      // idle cycles between the two keys are tolerated; open lasts one cycle
      key_ff       <= key_ff;
      half_seen_ff <= half_seen_ff;
    end
  end

  // register storage; only implemented bits are kept
  wire logic [15:0] wdat = HWDATA[15:0];
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      lock_ff <= 1'b0;
      sel0_ff <= REG_RESET;
      sel1_ff <= REG_RESET;
      sel2_ff <= REG_RESET;
    end else begin
      if (cfg_take) lock_ff <= wdat[LOCK_BIT];
      if (wr_sel0) sel0_ff <= wdat & SEL_HI_MASK;
      if (wr_sel1) sel1_ff <= wdat & SEL_FULL_MASK;
      if (wr_sel2) sel2_ff <= wdat & SEL_HI_MASK;
    end
  end

  // read mux; unmapped addresses read zero
  wire logic [15:0] cfg_rd = {4'h0, lock_ff, 11'h000};
  wire logic [15:0] rd_val =
    (addr_ff == ADDR_CONFIG) ? cfg_rd :
    (addr_ff == ADDR_SEL0)   ? sel0_ff :
    (addr_ff == ADDR_SEL1)   ? sel1_ff :
    (addr_ff == ADDR_SEL2)   ? sel2_ff : 16'h0000;

  // bus outputs: zero wait state, read data valid in data phase
  // read data registered from the address phase instead, to keep outputs
  // flop-driven; the decode uses the live address then
  wire logic [15:0] rd_live =
    (HADDR[11:0] == ADDR_CONFIG) ? cfg_rd :
    (HADDR[11:0] == ADDR_SEL0)   ? sel0_ff :
    (HADDR[11:0] == ADDR_SEL1)   ? sel1_ff :
    (HADDR[11:0] == ADDR_SEL2)   ? sel2_ff : 16'h0000;
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      HRDATA    <= 32'h0000_0000;
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
    end else begin
      HRDATA    <= (take && !HWRITE) ? {16'h0000, rd_live} : 32'h0000_0000;
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
    end
  end

  // peripheral routing; selectors are independent so pins may be shared
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      EXT_IRQ1         <= 1'b0;
      EXT_IRQ2         <= 1'b0;
      EXT_IRQ3         <= 1'b0;
      TIMER1_EXT_CLOCK <= 1'b0;
      REMAP_LOCK       <= 1'b0;
    end else begin
      EXT_IRQ1         <= pick_pin(pin_sync_ff, sel0_ff[15:8]);
      EXT_IRQ2         <= pick_pin(pin_sync_ff, sel1_ff[7:0]);
      EXT_IRQ3         <= pick_pin(pin_sync_ff, sel1_ff[15:8]);
      TIMER1_EXT_CLOCK <= pick_pin(pin_sync_ff, sel2_ff[15:8]);
      REMAP_LOCK       <= lock_ff;
    end
  end

  // checks
  a_lock_blocks: assert property (@(posedge CLK) disable iff (!rst_n)
    (lock_ff && wr_pend_ff) |=> $stable(sel0_ff) && $stable(sel1_ff)
      && $stable(sel2_ff)) else $error("select changed while locked");
  a_unlock_write: assert property (@(posedge CLK) disable iff (!rst_n)
    wr_sel1 |=> sel1_ff == $past(wdat)) else $error("select1 write lost");
  a_cfg_guard: assert property (@(posedge CLK) disable iff (!rst_n)
    (wr_cfg && key_ff != KEY_OPEN) |=> $stable(lock_ff))
    else $error("config written without keys");
  a_cfg_zero: assert property (@(posedge CLK) disable iff (!rst_n)
    (cfg_rd & ~CONFIG_MASK) == 16'h0000) else $error("config spare bits");
  a_sel0_low: assert property (@(posedge CLK) disable iff (!rst_n)
    sel0_ff[7:0] == 8'h00 && sel2_ff[7:0] == 8'h00)
    else $error("unimplemented bits set");
  a_route_irq1: assert property (@(posedge CLK) disable iff (!rst_n)
    $stable(sel0_ff) && sel0_ff[15:8] <= PIN_LAST |=>
    EXT_IRQ1 == $past(pin_sync_ff[sel0_ff[13:8]]))
    else $error("irq1 routing wrong");
  a_route_none: assert property (@(posedge CLK) disable iff (!rst_n)
    sel2_ff[15:8] > PIN_LAST |=> !TIMER1_EXT_CLOCK)
    else $error("timer clock not idle");
  a_key_window: assert property (@(posedge CLK) disable iff (!rst_n)
    key_ff == KEY_OPEN |=> key_ff == KEY_IDLE)
    else $error("key window too long");
  c_lock_set: cover property (@(posedge CLK) disable iff (!rst_n)
    cfg_take && wdat[LOCK_BIT]);
  c_locked_write: cover property (@(posedge CLK) disable iff (!rst_n)
    lock_ff && wr_pend_ff && addr_ff == ADDR_SEL1);
  c_shared_pin: cover property (@(posedge CLK) disable iff (!rst_n)
    sel1_ff[15:8] == sel1_ff[7:0] && sel1_ff[7:0] != 8'h00);
endmodule

/* tb/prl_pin_model.sv */
// far-side pin model: levels on the remappable pins
`timescale 1ns/1ps
module prl_pin_model (
  input  wire logic        invert,  // flip every pin level
  output logic      [63:0] pin_in   // levels seen on the pins
);
  // only pin 5 high in the base pattern; inverting it reaches every pin
  localparam logic [63:0] BASE = 64'h0000_0000_0000_0020;
  // pins carry input functions only, so the model never reads back
  assign pin_in = invert ? ~BASE : BASE;
endmodule

/* tb/tb.sv */
// self-checking bench: ahb-lite register access and pin routing
`timescale 1ns/1ps
module tb
  import prl_pkg::*;
;
  logic        CLK, RST_N, HSEL, HWRITE, HREADY, HREADYOUT, HRESP, invert;
  logic [31:0] HADDR, HWDATA, HRDATA;
  logic [1:0]  HTRANS;
  logic [2:0]  HSIZE;
  logic [63:0] PIN_IN;
  logic        EXT_IRQ1, EXT_IRQ2, EXT_IRQ3, TIMER1_EXT_CLOCK, REMAP_LOCK;
  int          fail_count, compares;
  logic [31:0] masks [3] = '{32'h0000_FF00, 32'h0000_FFFF, 32'h0000_FF00};
  // the single slave's ready is the bus ready
  assign HREADY = HREADYOUT;
  prl_remap dut_u (.CLK(CLK), .RST_N(RST_N), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HREADY(HREADY),
    .HWDATA(HWDATA), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
    .HRESP(HRESP), .PIN_IN(PIN_IN), .EXT_IRQ1(EXT_IRQ1),
    .EXT_IRQ2(EXT_IRQ2), .EXT_IRQ3(EXT_IRQ3),
    .TIMER1_EXT_CLOCK(TIMER1_EXT_CLOCK), .REMAP_LOCK(REMAP_LOCK));
  prl_pin_model pins_u (.invert(invert), .pin_in(PIN_IN));
  // clock source, 10 ns period
  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end
  task automatic chk(input string nm, input logic [31:0] exp, got);
    compares++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", nm, exp, got);
      fail_count++;
    end
  endtask
  task give_verdict;
    if (fail_count == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // tasks are entered just after a rising edge and leave just after one
  task automatic wait_rdy;
    do @(posedge CLK); while (HREADYOUT !== 1'b1);
  endtask
  task automatic addr_ph(input logic w, input logic [11:0] a);
    HSEL   <= 1'b1;
    HTRANS <= HTRANS_NONSEQ;
    HADDR  <= {20'h0_0000, a};
    HWRITE <= w;
    HSIZE  <= HSIZE_WORD;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    addr_ph(1'b1, a);
    wait_rdy();
    HSEL   <= 1'b0;
    HTRANS <= 2'b00;
    HWDATA <= d;
    wait_rdy();
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    addr_ph(1'b0, a);
    wait_rdy();
    HSEL   <= 1'b0;
    HTRANS <= 2'b00;
    wait_rdy();
    chk("read data", exp, HRDATA);
  endtask
  // keyed config write: config address phase directly follows second key
  task automatic cfg_wr(input logic [31:0] d);
    wr(ADDR_KEY, KEY_FIRST);
    addr_ph(1'b1, ADDR_KEY);
    wait_rdy();
    addr_ph(1'b1, ADDR_CONFIG);
    HWDATA <= KEY_SECOND;
    wait_rdy();
    HSEL   <= 1'b0;
    HTRANS <= 2'b00;
    HWDATA <= d;
    wait_rdy();
  endtask
  task automatic pins_chk(input logic inv, input logic [31:0] exp);
    invert <= inv;
    repeat (4) @(posedge CLK);
    chk("routed", {28'h0, EXT_IRQ1, EXT_IRQ2, EXT_IRQ3, TIMER1_EXT_CLOCK},
        exp);
  endtask
  // watchdog: the whole sequence needs well under 1000 cycles
  initial begin
    #50us;
    fail_count++;
    give_verdict();
  end
  initial begin
    {HSEL, HWRITE, invert} = 3'b000;
    HADDR = 32'h0000_0000;
    HWDATA = 32'h0000_0000;
    HTRANS = 2'b00;
    HSIZE = HSIZE_WORD;
    RST_N = 1'b0;
    repeat (6) @(posedge CLK);
    RST_N <= 1'b1;
    repeat (3) @(posedge CLK);
    chk("lock", {31'h0, REMAP_LOCK}, 32'h0);
    chk("hresp", {31'h0, HRESP}, 32'h0);
    for (int i = 0; i < 4; i++) rd(ADDR_CONFIG + 12'(4 * i), 32'h0);
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_SEL0 + 12'(4 * i), 32'hFFFF_FFFF);
      rd(ADDR_SEL0 + 12'(4 * i), masks[i]);
    end
    // pin 5 shared by two selectors, pin 63 on one, out-of-range on timer
    wr(ADDR_SEL0, 32'h0000_0500);
    wr(ADDR_SEL1, 32'h0000_3F05);
    wr(ADDR_SEL2, 32'h0000_4000);
    pins_chk(1'b0, 32'h0000_000C);
    pins_chk(1'b1, 32'h0000_0002);
    wr(ADDR_CONFIG, 32'h0000_0800);
    rd(ADDR_CONFIG, 32'h0);
    // the window shuts one cycle after the second key, so the config write behind the foreign write is ignored
    wr(ADDR_KEY, KEY_FIRST);
    wr(ADDR_KEY, KEY_SECOND);
    wr(ADDR_SEL2, 32'h0000_4000);
    wr(ADDR_CONFIG, 32'h0000_0800);
    rd(ADDR_CONFIG, 32'h0);
    cfg_wr(32'h0000_FFFF);
    rd(ADDR_CONFIG, 32'h0000_0800);
    chk("lock", {31'h0, REMAP_LOCK}, 32'h1);
    wr(ADDR_SEL0, 32'h0000_1200);
    rd(ADDR_SEL0, 32'h0000_0500);
    wr(ADDR_SEL1, 32'h0000_0000);
    rd(ADDR_SEL1, 32'h0000_3F05);
    cfg_wr(32'h0000_0000);
    rd(ADDR_CONFIG, 32'h0);
    chk("lock", {31'h0, REMAP_LOCK}, 32'h0);
    wr(ADDR_SEL0, 32'h0000_1200);
    rd(ADDR_SEL0, 32'h0000_1200);
    // unmapped place: writes dropped, reads zero
    wr(12'h020, 32'hFFFF_FFFF);
    rd(12'h020, 32'h0);
    give_verdict();
  end
endmodule
